// ==== qdac_pkg.sv ====
`default_nettype none
package qdac_pkg;
   localparam int unsigned QDAC_CH = 4;
   localparam int unsigned QDAC_FRAME_BITS = 16;
   localparam int unsigned QDAC_CODE_W = 12;
   localparam int unsigned QDAC_CNT_W = 5;
   localparam int unsigned QDAC_ADDR_W = 8;
   localparam int unsigned QDAC_COUNT_W = 16;
   // bit counter values in the link domain
   localparam logic [4:0] QDAC_LAST_BIT = 5'h0f;
   localparam logic [4:0] QDAC_DONE_BITS = 5'h10;
   localparam logic [4:0] QDAC_CNT_STEP = 5'h01;
   // positions inside the twelve data bits of a power-down frame
   localparam int unsigned QDAC_PD_ALL = 11;
   localparam int unsigned QDAC_PD_CH_HI = 10;
   localparam int unsigned QDAC_PD_CH_LO = 9;
   localparam int unsigned QDAC_PD_IMP_HI = 8;
   localparam int unsigned QDAC_PD_IMP_LO = 7;
   localparam logic [1:0] QDAC_IMP_1K = 2'h1;
   localparam logic [1:0] QDAC_IMP_100K = 2'h2;
   localparam logic [1:0] QDAC_PICK_PD = 2'h3;
   // register map, byte addresses
   localparam logic [7:0] QDAC_OFS_INPUT = 8'h00;
   localparam logic [7:0] QDAC_OFS_CONV = 8'h10;
   localparam logic [7:0] QDAC_OFS_OFF = 8'h20;
   localparam logic [7:0] QDAC_OFS_COUNT = 8'h24;
   localparam logic [7:0] QDAC_OFS_CTRL = 8'h28;
   localparam logic [7:0] QDAC_WORD_BYTES = 8'h04;
   localparam int unsigned QDAC_CTRL_EN = 0;
   localparam int unsigned QDAC_CTRL_CLR = 1;
   localparam logic QDAC_CTRL_EN_RST = 1'b1;
   localparam logic [15:0] QDAC_COUNT_STEP = 16'h0001;

   typedef enum logic [1:0] {
      QDAC_LD_STORE = 2'b00,
      QDAC_LD_UPDATE = 2'b01,
      QDAC_LD_BOTH = 2'b10,
      QDAC_LD_WIDE = 2'b11
   } qdac_load_t;

   typedef enum logic [1:0] {
      QDAC_OFF_NONE = 2'b00,
      QDAC_OFF_1K = 2'b01,
      QDAC_OFF_100K = 2'b10,
      QDAC_OFF_HIZ = 2'b11
   } qdac_off_t;

   typedef struct packed {
      logic load_ctrl_hi;
      logic load_ctrl_lo;
      logic channel_pick_hi;
      logic channel_pick_lo;
      logic [11:0] data;
   } qdac_frame_t;

   typedef struct packed {
      qdac_off_t output_off_state;
      logic [11:0] code;
   } qdac_chan_t;
endpackage
`default_nettype wire

// ==== qdac_serial_decoder.sv ====
// Summary of operation
// - frame is 16 bits msb first: two load, two pick, twelve data bits.
// - shift data on falling clock edges for sixteen pulses while select low.
// - select rising early aborts; a complete frame is applied automatically.
// - pick bits 00..11 address channels A..D unless both load bits are set.
// - load 01 copies input register to converter register, refreshes output.
// - load 10 writes data to both registers of the channel, refreshes output.
// - all four control bits set is a power-down command.
// - power-down with data bit 11 set acts on all four channels.
// - power-down with bit 11 clear acts on channel picked by bits 10..9.
// - impedance from bits 8..7: floating, one kilohm, 100 kilohm, floating.
// - data bits 6..0 are ignored in power-down frames.
// - link is clock, frame select and data in; no serial data out.
//
// Chosen here: the address map and the APB register port.
`default_nettype none
module qdac_serial_decoder
   import qdac_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [QDAC_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   output qdac_chan_t [QDAC_CH-1:0] chan_state
);

   // link domain
   logic [QDAC_CNT_W-1:0] bit_cnt;
   logic [QDAC_FRAME_BITS-2:0] shift;
   qdac_frame_t link_word;
   logic frame_tog;

   // pclk domain
   logic tog_meta;
   logic tog_sync;
   logic tog_seen;
   logic tog_edge;
   logic hold_valid;
   qdac_frame_t frame_word;
   logic frame_evt;
   logic link_en;
   logic soft_clr;
   logic [QDAC_COUNT_W-1:0] frame_count;
   logic [QDAC_CODE_W-1:0] in_reg [QDAC_CH];
   logic [QDAC_CODE_W-1:0] next_in_reg [QDAC_CH];
   qdac_chan_t [QDAC_CH-1:0] next_chan_state;
   qdac_load_t op;
   logic op_pd;
   logic [QDAC_CH-1:0] hit;
   logic [QDAC_CH-1:0] pd_hit;
   qdac_off_t pd_mode;
   logic apb_acc;
   logic [31:0] next_prdata;
   logic next_pslverr;

   // select high holds the receiver cleared, so an early rise throws the
   // partial word away before it can reach the hold register
   always_ff @(negedge sclk or posedge sync_n) begin
      if (sync_n) begin
         bit_cnt <= '0;
         shift <= '0;
      end else if (bit_cnt != QDAC_DONE_BITS) begin
         shift <= {shift[QDAC_FRAME_BITS-3:0], din};
         bit_cnt <= bit_cnt + QDAC_CNT_STEP;
      end
   end

   // receive only: nothing is driven back onto the link
   // the held word only changes sixteen clocks later, far longer than the
   // three pclk edges the toggle and the copy need to cross
   always_ff @(negedge sclk or negedge presetn) begin
      if (!presetn) begin
         link_word <= '0;
         frame_tog <= 1'b0;
      end else if (bit_cnt == QDAC_LAST_BIT) begin
         link_word <= {shift, din};
         frame_tog <= ~frame_tog;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
         tog_seen <= 1'b0;
      end else begin
         tog_meta <= frame_tog;
         tog_sync <= tog_meta;
         tog_seen <= tog_sync;
      end
   end

   assign tog_edge = tog_sync ^ tog_seen;

   // the link word is copied once, in the cycle the toggle edge is seen;
   // the decode below then reads only this pclk-side copy and never a
   // word that belongs to the other clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_word <= '0;
      end else if (tog_edge) begin
         frame_word <= link_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_valid <= 1'b0;
      end else begin
         hold_valid <= tog_edge;
      end
   end

   // a frame that lands while the link is disabled is dropped, not queued
   assign frame_evt = hold_valid & link_en;

   // the three non-power-down wide cases fold into the single-channel ones with every
   // channel hit, so one decode path serves both
   always_comb begin
      op_pd = 1'b0;
      op = qdac_load_t'({frame_word.load_ctrl_hi,
                         frame_word.load_ctrl_lo});
      if (op == QDAC_LD_WIDE) begin
         if ({frame_word.channel_pick_hi, frame_word.channel_pick_lo}
               == QDAC_PICK_PD) begin
            op_pd = 1'b1;
         end else begin
            op = qdac_load_t'({frame_word.channel_pick_hi,
                               frame_word.channel_pick_lo});
         end
      end
   end

   always_comb begin
      for (int i = 0; i < QDAC_CH; i++) begin
         hit[i] = ({frame_word.channel_pick_hi,
                    frame_word.channel_pick_lo} == 2'(i))
                  || ({frame_word.load_ctrl_hi,
                       frame_word.load_ctrl_lo} == QDAC_LD_WIDE);
         pd_hit[i] = frame_word.data[QDAC_PD_ALL]
                     || (frame_word.data[QDAC_PD_CH_HI:QDAC_PD_CH_LO]
                         == 2'(i));
      end
   end

   // low seven data bits are never looked at in a power-down frame
   always_comb begin
      case (frame_word.data[QDAC_PD_IMP_HI:QDAC_PD_IMP_LO])
         QDAC_IMP_1K: pd_mode = QDAC_OFF_1K;
         QDAC_IMP_100K: pd_mode = QDAC_OFF_100K;
         default: pd_mode = QDAC_OFF_HIZ;
      endcase
   end

   // refreshing a channel's output also brings it out of power-down
   always_comb begin
      next_in_reg = in_reg;
      next_chan_state = chan_state;
      if (soft_clr) begin
         for (int i = 0; i < QDAC_CH; i++) begin
            next_in_reg[i] = '0;
            next_chan_state[i] = '0;
         end
      end else if (frame_evt) begin
         for (int i = 0; i < QDAC_CH; i++) begin
            if (op_pd) begin
               if (pd_hit[i]) begin
                  next_chan_state[i].output_off_state = pd_mode;
               end
            end else if (hit[i]) begin
               case (op)
                  QDAC_LD_STORE: begin
                     next_in_reg[i] = frame_word.data;
                  end
                  QDAC_LD_UPDATE: begin
                     next_chan_state[i].code = in_reg[i];
                     next_chan_state[i].output_off_state = QDAC_OFF_NONE;
                  end
                  QDAC_LD_BOTH: begin
                     next_in_reg[i] = frame_word.data;
                     next_chan_state[i].code = frame_word.data;
                     next_chan_state[i].output_off_state = QDAC_OFF_NONE;
                  end
                  default: begin
                     next_in_reg[i] = in_reg[i];
                  end
               endcase
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < QDAC_CH; i++) begin
            in_reg[i] <= '0;
         end
         chan_state <= '0;
      end else begin
         in_reg <= next_in_reg;
         chan_state <= next_chan_state;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_count <= '0;
      end else if (soft_clr) begin
         frame_count <= '0;
      end else if (frame_evt) begin
         frame_count <= frame_count + QDAC_COUNT_STEP;
      end
   end

   // apb: one wait state, then pready for one cycle
   assign apb_acc = psel & penable & pready;

   always_comb begin
      next_prdata = '0;
      next_pslverr = 1'b1;
      for (int i = 0; i < QDAC_CH; i++) begin
         if (paddr == QDAC_OFS_INPUT + 8'(QDAC_WORD_BYTES * 8'(i))) begin
            next_prdata = 32'(in_reg[i]);
            next_pslverr = 1'b0;
         end
         if (paddr == QDAC_OFS_CONV + 8'(QDAC_WORD_BYTES * 8'(i))) begin
            next_prdata = 32'(chan_state[i].code);
            next_pslverr = 1'b0;
         end
      end
      if (paddr == QDAC_OFS_OFF) begin
         for (int i = 0; i < QDAC_CH; i++) begin
            next_prdata[2*i +: 2] = chan_state[i].output_off_state;
         end
         next_pslverr = 1'b0;
      end
      if (paddr == QDAC_OFS_COUNT) begin
         next_prdata = 32'(frame_count);
         next_pslverr = 1'b0;
      end
      if (paddr == QDAC_OFS_CTRL) begin
         next_prdata[QDAC_CTRL_EN] = link_en;
         next_pslverr = 1'b0;
      end
      if (pwrite) begin
         next_prdata = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end else begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_en <= QDAC_CTRL_EN_RST;
         soft_clr <= 1'b0;
      end else if (apb_acc && pwrite && paddr == QDAC_OFS_CTRL) begin
         link_en <= pwdata[QDAC_CTRL_EN];
         soft_clr <= pwdata[QDAC_CTRL_CLR];
      end else begin
         soft_clr <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ==== qdac_sva.sv ====
`default_nettype none
module qdac_sva
   import qdac_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [QDAC_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   input wire qdac_chan_t [QDAC_CH-1:0] chan_state
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] quiet;
   // a frame lands a few cycles after select rises; eight leaves margin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) quiet <= 4'h0;
      else if (!sync_n) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
   end
   a_ready_pulse: assert property (pready |=> !pready) else $error("held");
   a_ready_wait: assert property (psel && $rose(penable) |=> pready)
      else $error("pready late");
   a_ready_cause: assert property (pready |-> psel && penable)
      else $error("pready unasked");
   a_err_pair: assert property (pslverr |-> pready) else $error("lone err");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not idle");
   a_map_miss: assert property (pready && paddr > QDAC_OFS_CTRL |-> pslverr)
      else $error("no pslverr");
   a_map_hit: assert property (pready && paddr[1:0] == 2'h0 &&
      paddr <= QDAC_OFS_CTRL |-> !pslverr) else $error("bad pslverr");
   a_state_quiet: assert property ($changed(chan_state) |->
      quiet < 4'h8 || $past(pready) || $past(pready, 2) || $past(pready, 3))
      else $error("state moved");
   c_err: cover property (pslverr);
   c_read: cover property (pready && !pwrite);
   c_frame: cover property ($changed(chan_state));
endmodule
`default_nettype wire

// ==== qdac_host.sv ====
`default_nettype none
module qdac_host (
   output var logic sclk,
   output var logic sync_n,
   output var logic din
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      din = 1'b0;
   end
   // clock parks high between frames; pulses past sixteen carry ones
   task automatic send(input logic [15:0] w, input int n);
      sync_n = 1'b0;
      #9;
      for (int i = 0; i < n; i++) begin
         din = (i < 16) ? w[15 - i] : 1'b1;
         #16 sclk = 1'b0;
         #16 sclk = 1'b1;
      end
      #7 sync_n = 1'b1;
      din = ~din;
      #40;
   endtask
endmodule
`default_nettype wire

// ==== qdac_serial_decoder_bench.sv ====
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   err_count++; $display("unexpected at %0t: %h", $time, a); end end
module qdac_serial_decoder_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import qdac_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, sclk, sync_n, din, er;
   logic en = 1'b1;
   qdac_chan_t [QDAC_CH-1:0] chan_state;
   int err_count = 0;
   int samples_checked = 0;
   int frames;
   logic [11:0] inr [4];
   logic [11:0] conv [4];
   logic [1:0] off [4];
   qdac_serial_decoder i_qdac_serial_decoder (
      .pclk(pclk),
      .presetn(presetn),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .sclk(sclk),
      .sync_n(sync_n),
      .din(din),
      .chan_state(chan_state)
   );
   qdac_host i_qdac_host (.sclk(sclk), .sync_n(sync_n), .din(din));
   initial begin
      forever #25 pclk = ~pclk;
   end
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      `CHK(pready, 1'b1)
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic clear_model();
      for (int i = 0; i < 4; i++) begin
         inr[i] = 12'h0;
         conv[i] = 12'h0;
         off[i] = 2'h0;
      end
      frames = 0;
   endtask
   task automatic check_all();
      for (int i = 0; i < 4; i++) begin
         `CHK(chan_state[i].code, conv[i])
         `CHK(chan_state[i].output_off_state, off[i])
         apb(QDAC_OFS_INPUT + 8'(4 * i), 1'b0, 32'h0);
         `CHK(rd, {20'h0, inr[i]})
         apb(QDAC_OFS_CONV + 8'(4 * i), 1'b0, 32'h0);
         `CHK(rd, {20'h0, conv[i]})
      end
      apb(QDAC_OFS_OFF, 1'b0, 32'h0);
      `CHK(rd, {24'h0, off[3], off[2], off[1], off[0]})
   endtask
   task automatic apply(input logic [15:0] w);
      logic [1:0] st;
      logic hit;
      st = (w[15:14] == 2'h3) ? w[13:12] : w[15:14];
      for (int i = 0; i < 4; i++) begin
         hit = (w[15:14] == 2'h3) || (w[13:12] == 2'(i));
         if (w[15:12] == 4'hf) begin
            if (w[11] || w[10:9] == 2'(i))
               off[i] = (w[8:7] == 2'h0) ? 2'h3 : w[8:7];
         end else if (hit) begin
            if (st != 2'h1) inr[i] = w[11:0];
            if (st != 2'h0) conv[i] = (st == 2'h1) ? inr[i] : w[11:0];
            if (st != 2'h0) off[i] = 2'h0;
         end
      end
   endtask
   task automatic frame(input logic [15:0] w, input int n);
      i_qdac_host.send(w, n);
      if (n >= 16 && en) begin
         apply(w);
         frames++;
      end
      repeat (9) @(posedge pclk);
      check_all();
   endtask
   task automatic give_verdict();
      $display("%0d mismatches in %0d checks", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      clear_model();
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(QDAC_OFS_CTRL, 1'b0, 32'h0);
      `CHK(rd, 32'h1)
      apb(8'h40, 1'b0, 32'h0);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h0)
      for (int i = 0; i < 4; i++)
         frame({2'h0, 2'(i), 12'h111 * 12'(i + 1)}, 16);
      frame(16'h5abc, 16);
      frame(16'ha123, 20);
      frame(16'h9777, 10);
      frame(16'hc0aa, 16);
      frame(16'hd000, 16);
      frame(16'he456, 16);
      $display("load tests over");
      for (int i = 0; i < 4; i++)
         frame({4'hf, 1'b0, 2'(i), 2'(i), 7'h5a}, 16);
      frame(16'hfeff, 16);
      $display("power-down tests over");
      apb(QDAC_OFS_COUNT, 1'b0, 32'h0);
      `CHK(rd, 32'(frames))
      apb(QDAC_OFS_CTRL, 1'b1, 32'h0);
      en = 1'b0;
      frame(16'h8fff, 16);
      apb(QDAC_OFS_COUNT, 1'b0, 32'h0);
      `CHK(rd, 32'(frames))
      apb(QDAC_OFS_CTRL, 1'b1, 32'h3);
      en = 1'b1;
      // the clear lands one edge after the write is taken
      @(posedge pclk);
      clear_model();
      check_all();
      apb(QDAC_OFS_COUNT, 1'b0, 32'h0);
      `CHK(rd, 32'(frames))
      apb(QDAC_OFS_CTRL, 1'b0, 32'h0);
      `CHK(rd, 32'h1)
      $display("control tests over");
      give_verdict();
   end
   initial begin
      #200000;
      err_count++;
      give_verdict();
   end
endmodule
bind qdac_serial_decoder qdac_sva i_qdac_sva (
   .pclk(pclk),
   .presetn(presetn),
   .paddr(paddr),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .sclk(sclk),
   .sync_n(sync_n),
   .din(din),
   .chan_state(chan_state)
);
`default_nettype wire
